// *** ide_slave_timing_defs.vh ***
// Offsets, field positions and clock counts for the drive 1 timing block
`ifndef IDE_SLAVE_TIMING_DEFS_VH
`define IDE_SLAVE_TIMING_DEFS_VH
`define CFG_ADDR_W 8
`define OFF_DRIVE1_PIO_TIMING 8'h44
`define OFF_SYNC_DMA_ENABLE 8'h48
`define RST_DRIVE1_PIO_TIMING 8'h00
`define RST_SYNC_DMA_ENABLE 8'h00
`define RST_RD_DATA 8'h00
`define COMPAT_CLOCKS 3'h0
`define SDMA_WR_MASK 8'h0F
`define SEC_SP_HI 7
`define SEC_SP_LO 6
`define SEC_RC_HI 5
`define SEC_RC_LO 4
`define PRI_SP_HI 3
`define PRI_SP_LO 2
`define PRI_RC_HI 1
`define PRI_RC_LO 0
`define SP_5CLK 2'h0
`define SP_4CLK 2'h1
`define SP_3CLK 2'h2
`define SP_RSVD 2'h3
`define RC_4CLK 2'h0
`define RC_3CLK 2'h1
`define RC_2CLK 2'h2
`define RC_1CLK 2'h3
`define CNT_W 3
`define CLK5 3'h5
`define CLK4 3'h4
`define CLK3 3'h3
`define CLK2 3'h2
`define CLK1 3'h1
`endif

// *** ide_slave_timing.v ***
// Drive 1 timing and synchronous DMA enable configuration registers
`timescale 1ns/100ps
`include "ide_slave_timing_defs.vh"
module ide_slave_timing (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Configuration access
    input wire cfgWrite,
    input wire cfgRead,
    input wire [7:0] cfgAddr,
    input wire [7:0] cfgWrData,
    output reg [7:0] cfgRdData,
    // Main timing register bits, primary then secondary
    input wire [1:0] separateD1Timing,
    input wire [1:0] drive1FastTiming,
    // Access being timed: channel 0 primary, 1 secondary
    input wire [1:0] drive1DataAccess,
    // Resulting timing per channel, 0 means use compatible timing
    output wire [1:0] useD1Timing,
    output wire [5:0] sampleClocks,
    output wire [5:0] recoveryClocks,
    output wire [1:0] sampleReserved,
    // Sync DMA enables
    output wire secD1SyncDmaEn,
    output wire secD0SyncDmaEn,
    output wire priD1SyncDmaEn,
    output wire priD0SyncDmaEn
);

// ----------------------------------------
// Storage and decode signals
// ----------------------------------------
// Register contents
reg [7:0] drive1PioTiming_r;
reg [7:0] syncDmaEnable_r;
// Next values of both registers
reg [7:0] drive1PioTiming_nxt;
reg [7:0] syncDmaEnable_nxt;
// Read mux output and next read data
reg [7:0] rdData_nxt;
reg [7:0] cfgRdData_nxt;
// Offset hits
wire hitTiming;
wire hitSyncDma;
// Write strobes per register
wire wrTiming;
wire wrSyncDma;

// ----------------------------------------
// Address decode
// ----------------------------------------
// Full byte compare, so nearby offsets stay unmapped
assign hitTiming = (cfgAddr == `OFF_DRIVE1_PIO_TIMING);
assign hitSyncDma = (cfgAddr == `OFF_SYNC_DMA_ENABLE);
// A write lands only on a mapped offset
assign wrTiming = cfgWrite & hitTiming;
assign wrSyncDma = cfgWrite & hitSyncDma;

// ----------------------------------------
// Register next values
// ----------------------------------------
// Timing register takes the whole byte
always @*
begin
    drive1PioTiming_nxt = drive1PioTiming_r;
    if (wrTiming)
    begin
        drive1PioTiming_nxt = cfgWrData;
    end
end

// Enable register drops the reserved upper nibble
always @*
begin
    syncDmaEnable_nxt = syncDmaEnable_r;
    if (wrSyncDma)
    begin
        syncDmaEnable_nxt = cfgWrData & `SDMA_WR_MASK;
    end
end

// ----------------------------------------
// Register state
// ----------------------------------------
// Both registers clear on the synchronous reset
always @(posedge ref_clk)
begin
    if (!reset_n)
    begin
        drive1PioTiming_r <= `RST_DRIVE1_PIO_TIMING;
        syncDmaEnable_r <= `RST_SYNC_DMA_ENABLE;
    end
    else
    begin
        drive1PioTiming_r <= drive1PioTiming_nxt;
        syncDmaEnable_r <= syncDmaEnable_nxt;
    end
end

// ----------------------------------------
// Register reads
// ----------------------------------------
// Read mux, unmapped offsets read zero
always @*
begin
    rdData_nxt = `RST_RD_DATA;
    if (hitTiming)
    begin
        rdData_nxt = drive1PioTiming_r;
    end
    else if (hitSyncDma)
    begin
        rdData_nxt = syncDmaEnable_r & `SDMA_WR_MASK;
    end
end

// Read data only moves on a read, so software sees a stable byte
always @*
begin
    cfgRdData_nxt = cfgRdData;
    if (cfgRead)
    begin
        cfgRdData_nxt = rdData_nxt;
    end
end

// Read data register; a read beside a write returns the old value
always @(posedge ref_clk)
begin
    if (!reset_n)
    begin
        cfgRdData <= `RST_RD_DATA;
    end
    else
    begin
        cfgRdData <= cfgRdData_nxt;
    end
end

// ----------------------------------------
// Sync DMA enables
// ----------------------------------------
// One enable per drive, straight from the stored bits
assign secD1SyncDmaEn = syncDmaEnable_r[3];
assign secD0SyncDmaEn = syncDmaEnable_r[2];
assign priD1SyncDmaEn = syncDmaEnable_r[1];
assign priD0SyncDmaEn = syncDmaEnable_r[0];

// ----------------------------------------
// Per-channel timing decode
// ----------------------------------------
// Fields of one channel: sample point above recovery
wire [3:0] chanFields [0:1];
assign chanFields[0] = {drive1PioTiming_r[`PRI_SP_HI:`PRI_SP_LO],
                        drive1PioTiming_r[`PRI_RC_HI:`PRI_RC_LO]};
assign chanFields[1] = {drive1PioTiming_r[`SEC_SP_HI:`SEC_SP_LO],
                        drive1PioTiming_r[`SEC_RC_HI:`SEC_RC_LO]};

// Primary and secondary decode alike, channel 0 primary
genvar ch;
generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : gChan
        // Decoded counts of this channel
        reg [2:0] spCnt;
        reg [2:0] rcCnt;
        // Only drive 1 data port, fast timing and separate timing
        assign useD1Timing[ch] = drive1DataAccess[ch] & drive1FastTiming[ch]
                                 & separateD1Timing[ch];
        // Sample point encoding; reserved code falls back to the slowest point
        always @*
        begin
            case (chanFields[ch][3:2])
                `SP_5CLK: spCnt = `CLK5;
                `SP_4CLK: spCnt = `CLK4;
                `SP_3CLK: spCnt = `CLK3;
                `SP_RSVD: spCnt = `CLK5;
                default: spCnt = `CLK5;
            endcase
        end
        // Recovery encoding, every code legal
        always @*
        begin
            case (chanFields[ch][1:0])
                `RC_4CLK: rcCnt = `CLK4;
                `RC_3CLK: rcCnt = `CLK3;
                `RC_2CLK: rcCnt = `CLK2;
                `RC_1CLK: rcCnt = `CLK1;
                default: rcCnt = `CLK1;
            endcase
        end
        // Zero counts tell the strobe engine to use compatible timing
        assign sampleClocks[ch*3 +: 3] = useD1Timing[ch] ? spCnt : `COMPAT_CLOCKS;
        assign recoveryClocks[ch*3 +: 3] = useD1Timing[ch] ? rcCnt : `COMPAT_CLOCKS;
        // Reserved code is flagged only while the fields are in use
        assign sampleReserved[ch] = useD1Timing[ch] &
                                    (chanFields[ch][3:2] == `SP_RSVD);
    end
endgenerate

endmodule

// *** ide_slave_timing_sva.sv ***
// Port assertions for the drive 1 timing registers
`timescale 1ns/100ps
module ide_slave_timing_sva(input wire ref_clk, reset_n, cfgWrite, cfgRead,
    input wire [7:0] cfgAddr, cfgWrData, cfgRdData, input wire [1:0] separateD1Timing,
    drive1FastTiming, drive1DataAccess, useD1Timing, sampleReserved,
    input wire [5:0] sampleClocks, recoveryClocks,
    input wire secD1SyncDmaEn, secD0SyncDmaEn, priD1SyncDmaEn, priD0SyncDmaEn);
default clocking @(posedge ref_clk); endclocking
default disable iff (!reset_n);
property p_use; useD1Timing == (separateD1Timing & drive1FastTiming & drive1DataAccess);
endproperty
a_use: assert property (p_use) else $error("select");
property p_off0; !useD1Timing[0] |-> sampleClocks[2:0] == 3'h0 && recoveryClocks[2:0] == 3'h0;
endproperty
a_off0: assert property (p_off0) else $error("pri off");
property p_off1; !useD1Timing[1] |-> sampleClocks[5:3] == 3'h0 && recoveryClocks[5:3] == 3'h0;
endproperty
a_off1: assert property (p_off1) else $error("sec off");
property p_rsv; sampleReserved[0] |-> sampleClocks[2:0] == 3'h5; endproperty
a_rsv: assert property (p_rsv) else $error("reserved");
property p_sp; useD1Timing[1] |-> sampleClocks[5:3] inside {[3'h3:3'h5]}; endproperty
a_sp: assert property (p_sp) else $error("sample");
property p_rec; useD1Timing[1] |-> recoveryClocks[5:3] inside {[3'h1:3'h4]}; endproperty
a_rec: assert property (p_rec) else $error("recovery");
property p_en; cfgWrite && cfgAddr == 8'h48 |=> {secD1SyncDmaEn, secD0SyncDmaEn,
    priD1SyncDmaEn, priD0SyncDmaEn} == $past(cfgWrData[3:0]); endproperty
a_en: assert property (p_en) else $error("enables");
property p_rd; cfgRead && cfgAddr == 8'h48 |=> cfgRdData[7:4] == 4'h0; endproperty
a_rd: assert property (p_rd) else $error("reserved read");
property p_hold; !cfgRead |=> $stable(cfgRdData); endproperty
a_hold: assert property (p_hold) else $error("read hold");
c_wr: cover property (cfgWrite && cfgAddr == 8'h44);
c_use: cover property (useD1Timing == 2'h3);
c_rsv: cover property (sampleReserved != 2'h0);
endmodule

// *** ide_drive_model.sv ***
// Drive side: picks separate, fast and data-port access per channel
`timescale 1ns/100ps
module ide_drive_model(input wire [5:0] mode, output wire [1:0] separate, fast, access);
// Mode bits passed as the drive's access kind
assign {separate, fast, access} = mode;
endmodule

// *** ide_slave_timing_tb_top.sv ***
// Bench for the drive 1 timing and sync DMA enable registers
`timescale 1ns/100ps
module ide_slave_timing_tb_top;
reg ref_clk = 1'b0, reset_n = 1'b0, cfgWrite = 1'b0, cfgRead = 1'b0, rdv = 1'b0;
reg [7:0] cfgAddr = 8'h00, cfgWrData = 8'h00, r44 = 8'h00, r48 = 8'h00;
reg [5:0] mode = 6'h00;
reg [31:0] x = 32'h2CE1;
reg [25:0] q[$], e;
integer n_errors = 0, n_checks = 0, i, k;
wire [7:0] cfgRdData;
wire [1:0] sep, fast, acc, useD1Timing, srv;
wire [5:0] sampleClocks, recoveryClocks;
wire [3:0] en;
wire [1:0] u = mode[5:4] & mode[3:2] & mode[1:0];
wire [25:0] g = {srv, en, sampleClocks[5:3], recoveryClocks[5:3], sampleClocks[2:0],
    recoveryClocks[2:0], cfgRdData};
ide_drive_model drv(.mode(mode), .separate(sep), .fast(fast), .access(acc));
ide_slave_timing dut(.ref_clk(ref_clk), .reset_n(reset_n), .cfgWrite(cfgWrite),
    .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .separateD1Timing(sep), .drive1FastTiming(fast), .drive1DataAccess(acc),
    .useD1Timing(useD1Timing), .sampleClocks(sampleClocks), .recoveryClocks(recoveryClocks),
    .sampleReserved(srv), .secD1SyncDmaEn(en[3]), .secD0SyncDmaEn(en[2]),
    .priD1SyncDmaEn(en[1]), .priD0SyncDmaEn(en[0]));
// Expected sample and recovery counts of one channel
function [5:0] f(input [3:0] n, input s);
    f = s ? {n[3:2] == 2'h2 ? 3'h3 : n[3:2] == 2'h1 ? 3'h4 : 3'h5,
        3'h4 - {1'b0, n[1:0]}} : 6'h0;
endfunction
function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
endfunction
task acc_t(input w, input r, input [7:0] a, input [7:0] v);
    @(posedge ref_clk);
    #1 {cfgWrite, cfgRead, cfgAddr, cfgWrData} = {w, r, a, v};
endtask
task rd(input [7:0] a, input [7:0] v);
    acc_t(1'b0, 1'b1, a, 8'h00);
    q.push_back({u[1] & (r44[7:6] == 2'h3), u[0] & (r44[3:2] == 2'h3),
        r48[3:0], f(r44[7:4], u[1]), f(r44[3:0], u[0]), v});
endtask
task close_out;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
initial forever #2 ref_clk = ~ref_clk;
// Main sequence: reset values, random writes, readback, unmapped place
initial
begin
    repeat (5) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    rd(8'h44, 8'h00);
    rd(8'h48, 8'h00);
    for (i = 0; i < 24; i = i + 1)
    begin
        x = xs(x);
        acc_t(1'b1, 1'b0, 8'h44, x[7:0]);
        acc_t(1'b1, 1'b0, 8'h48, x[15:8]);
        acc_t(1'b1, 1'b0, 8'h4C, x[23:16]);
        {mode, r44, r48} = {x[29:24], x[7:0], 4'h0, x[11:8]};
        rd(8'h44, r44);
        rd(8'h48, r48);
        rd(8'h50, 8'h00);
    end
    acc_t(1'b0, 1'b0, 8'h00, 8'h00);
    for (k = 0; k < 8 && q.size() != 0; k = k + 1) @(posedge ref_clk);
    if (q.size() != 0)
    begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED reads expected 0 left seen %0d", q.size());
    end
    close_out;
end
// Watcher: compares each read answer with the oldest note
always @(posedge ref_clk)
begin
    #2 if (rdv)
    begin
        e = q.pop_front();
        n_checks = n_checks + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED read expected %h seen %h", e, g);
        end
    end
    rdv = cfgRead;
end
endmodule
bind ide_slave_timing ide_slave_timing_sva sva(.*);
